// File: inc/tdsr_consts.vh
// Purpose: constants of the thermal and device status register bank
// Assumes: included by the status register and assertion files of the bank
// Notes:   definitions only
`ifndef TDSR_CONSTS_VH
`define TDSR_CONSTS_VH

////////////////////////////////////////////////////////////////////////
// register map
`define TDSR_ADDR_W          7
`define TDSR_DATA_W          16
`define TDSR_ADDR_THERM      7'h41
`define TDSR_ADDR_DEV        7'h42

////////////////////////////////////////////////////////////////////////
// thermal protection status fields
`define TDSR_TH_SAFE_BIT     3
`define TDSR_TH_SEVERE_BIT   2
`define TDSR_TH_LOCAL_BIT    1
`define TDSR_TH_PREWARN_BIT  0
`define TDSR_TH_FLAG_W       4

////////////////////////////////////////////////////////////////////////
// device information status fields
`define TDSR_DV_CRC_EN_BIT   9
`define TDSR_DV_CRC_FAIL_BIT 8
`define TDSR_DV_PRIOR_HI     7
`define TDSR_DV_PRIOR_LO     6
`define TDSR_DV_RSVD5_BIT    5
`define TDSR_DV_SWDEV_BIT    4
`define TDSR_DV_WDC_HI       3
`define TDSR_DV_WDC_LO       2
`define TDSR_DV_SPI_FAIL_BIT 1
`define TDSR_DV_FAILURE_BIT  0

// sticky flags of the device register, packed {crc_fail, spi, failure}
`define TDSR_DV_FLAG_W       3
`define TDSR_DV_F_CRC        2
`define TDSR_DV_F_SPI        1
`define TDSR_DV_F_FAIL       0

////////////////////////////////////////////////////////////////////////
// field codes and reset values
`define TDSR_PRIOR_CLEARED   2'h0
`define TDSR_PRIOR_RESTART   2'h1
`define TDSR_PRIOR_SLEEP     2'h2
`define TDSR_WDC_ZERO        2'h0
`define TDSR_WDC_ONE         2'h1
`define TDSR_WDC_MAX         2'h3
`define TDSR_SAFE_CNT_W      5
`define TDSR_SAFE_LIMIT      5'h10
`define TDSR_SAFE_CNT_ZERO   5'h00
`define TDSR_SAFE_CNT_ONE    5'h01
`define TDSR_ZERO16          16'h0000

`endif

// File: hw/tdsr_sticky_flags.v
// Purpose: bank of sticky status flags with set-over-clear priority
// Assumes: set and clr are synchronous pulses or levels on sys_clk
// Notes:   flush clears every flag and wins over set
`timescale 1ns/1ps

module tdsr_sticky_flags
#(
  parameter W = 4
)
(
  input  wire         sys_clk,
  input  wire         rst_n,
  input  wire         flush,
  input  wire [W-1:0] set,
  input  wire [W-1:0] clr,
  output wire [W-1:0] flags
);

  ////////////////////////////////////////////////////////////////////
  // one flop per flag
  genvar i;
  generate
    for (i = 0; i < W; i = i + 1)
    begin : g_flag
      reg flag_q;
      reg flag_d;

      always @*
      begin
        flag_d = flag_q;
        if (flush)
          flag_d = 1'b0;
        else if (set[i])
          flag_d = 1'b1;
        else if (clr[i])
          flag_d = 1'b0;
      end

      always @(posedge sys_clk or negedge rst_n)
      begin
        if (!rst_n)
          flag_q <= 1'b0;
        else
          flag_q <= flag_d;
      end

      assign flags[i] = flag_q;
    end
  endgenerate

endmodule

// File: hw/tdsr_status_regs.v
// Purpose: thermal protection and device information status registers
// Assumes: serial framing, checksum check, watchdog and mode control
//          live outside and hand in decoded commands and event pulses
// Notes:   read data is registered on the same edge that takes the request
`timescale 1ns/1ps
`include "tdsr_consts.vh"

// Contract
// - thermal register bits 15 to 4 always read zero
// - safe-state flag sets after more than 16 consecutive severe shutdowns
// - severe overtemperature sets bit 2 and requests fail-safe mode
// - module overtemperature sets bit 1 and disables that module
// - thermal pre-warning sets bit 0
// - thermal flags stay set after the condition goes away
// - power-on or soft reset clears thermal register; restart keeps flags
// - bit 9 shows whether frame checksum checking is enabled
// - checksum failure sets bit 8, except during enable/disable sequence
// - prior-mode field: 01 failure or fail-safe wake, 10 sleep
// - prior-mode field holds until the host clears it to 00
// - sleep attempt with wake flags pending reports the sleep code
// - bit 4 follows the software development mode
// - watchdog failure counter saturates at 3, cleared only by device
// - invalid serial command sets bit 1, cleared only by serial command
// - checksum enable and failure bits readable in any checksum setting
// - device information read ignores the frame checksum
// - device information bits 15 to 10 always read zero
// - reset clears device register; restart keeps fields, bit 5 zero
module tdsr_status_regs
#(
  parameter ADDR_W = `TDSR_ADDR_W,
  parameter DATA_W = `TDSR_DATA_W
)
(
  input  wire              sys_clk,
  input  wire              rst_n,
  input  wire              soft_reset,
  input  wire              cmd_valid,
  input  wire [ADDR_W-1:0] cmd_addr,
  input  wire              cmd_rdclr,
  input  wire              cmd_crc_ok,
  input  wire              crc_enabled,
  input  wire              crc_seq_active,
  input  wire              crc_fail_evt,
  input  wire              prewarn_evt,
  input  wire              local_sd_evt,
  input  wire              severe_sd_evt,
  input  wire              severe_chain_break,
  input  wire              invalid_cmd_evt,
  input  wire              failure_evt,
  input  wire              restart_fail_evt,
  input  wire              sleep_entry_evt,
  input  wire              sleep_no_wake_evt,
  input  wire              software_development_indicator_mode,
  input  wire              watchdog_failure_counter_evt,
  input  wire              watchdog_failure_counter_clear,
  output reg  [DATA_W-1:0] rd_data_q,
  output reg               rd_valid_q,
  output reg               fail_safe_req_q,
  output reg               module_disable_q,
  output reg               long_wait_sel_q
);

  ////////////////////////////////////////////////////////////////////
  // address decode, shared by access and read path
  function is_therm;
    input [ADDR_W-1:0] a;
    begin
      is_therm = (a == `TDSR_ADDR_THERM);
    end
  endfunction

  function is_dev;
    input [ADDR_W-1:0] a;
    begin
      is_dev = (a == `TDSR_ADDR_DEV);
    end
  endfunction

  ////////////////////////////////////////////////////////////////////
  // declarations
  wire [`TDSR_TH_FLAG_W-1:0]  th_flags;
  wire [`TDSR_TH_FLAG_W-1:0]  th_set;
  wire [`TDSR_TH_FLAG_W-1:0]  th_clr;
  wire [`TDSR_DV_FLAG_W-1:0]  dv_flags;
  wire [`TDSR_DV_FLAG_W-1:0]  dv_set;
  wire [`TDSR_DV_FLAG_W-1:0]  dv_clr;
  wire                        acc_therm;
  wire                        acc_dev;
  wire                        clr_therm;
  wire                        clr_dev;
  wire                        safe_hit;
  reg  [`TDSR_SAFE_CNT_W-1:0] safe_cnt_q;
  reg  [`TDSR_SAFE_CNT_W-1:0] safe_cnt_d;
  reg  [1:0]                  prior_q;
  reg  [1:0]                  prior_d;
  reg  [1:0]                  wdc_q;
  reg  [1:0]                  wdc_d;
  reg                         swdev_q;
  reg                         crc_en_q;
  reg  [DATA_W-1:0]           therm_word;
  reg  [DATA_W-1:0]           dev_word;
  reg  [DATA_W-1:0]           rd_data_d;

  ////////////////////////////////////////////////////////////////////
  // access qualification
  // the thermal register obeys the checksum when checking is enabled
  assign acc_therm = cmd_valid && is_therm(cmd_addr)
                     && (!crc_enabled || cmd_crc_ok);
  // device information is served whatever the frame checksum says
  assign acc_dev   = cmd_valid && is_dev(cmd_addr);

  assign clr_therm = acc_therm && cmd_rdclr;
  assign clr_dev   = acc_dev && cmd_rdclr;

  ////////////////////////////////////////////////////////////////////
  // consecutive severe shutdown counter
  // counts up to the limit; the next event beyond it marks safe state
  assign safe_hit = severe_sd_evt
                    && (safe_cnt_q == `TDSR_SAFE_LIMIT);

  always @*
  begin
    safe_cnt_d = safe_cnt_q;
    if (soft_reset)
      safe_cnt_d = `TDSR_SAFE_CNT_ZERO;
    else if (severe_sd_evt && severe_chain_break)
      safe_cnt_d = `TDSR_SAFE_CNT_ONE;
    else if (severe_chain_break)
      safe_cnt_d = `TDSR_SAFE_CNT_ZERO;
    else if (severe_sd_evt && safe_cnt_q != `TDSR_SAFE_LIMIT)
      safe_cnt_d = safe_cnt_q + `TDSR_SAFE_CNT_ONE;
  end

  always @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      safe_cnt_q <= `TDSR_SAFE_CNT_ZERO;
    else
      safe_cnt_q <= safe_cnt_d;
  end

  ////////////////////////////////////////////////////////////////////
  // thermal sticky flags
  // flags only fall on a read-and-clear or reset, never by themselves
  assign th_set[`TDSR_TH_SAFE_BIT]    = safe_hit;
  assign th_set[`TDSR_TH_SEVERE_BIT]  = severe_sd_evt;
  assign th_set[`TDSR_TH_LOCAL_BIT]   = local_sd_evt;
  assign th_set[`TDSR_TH_PREWARN_BIT] = prewarn_evt;
  assign th_clr = {`TDSR_TH_FLAG_W{clr_therm}};

  tdsr_sticky_flags
  #(
    .W (`TDSR_TH_FLAG_W)
  )
  u_th_flags
  (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .flush   (soft_reset),
    .set     (th_set),
    .clr     (th_clr),
    .flags   (th_flags)
  );

  ////////////////////////////////////////////////////////////////////
  // thermal reactions toward the rest of the device
  always @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      fail_safe_req_q  <= 1'b0;
      module_disable_q <= 1'b0;
      long_wait_sel_q  <= 1'b0;
    end
    else
    begin
      fail_safe_req_q  <= severe_sd_evt;
      module_disable_q <= local_sd_evt;
      if (soft_reset || severe_chain_break)
        long_wait_sel_q <= 1'b0;
      else if (safe_hit)
        long_wait_sel_q <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // device information sticky flags
  assign dv_set[`TDSR_DV_F_CRC]  = crc_fail_evt && !crc_seq_active;
  assign dv_set[`TDSR_DV_F_SPI]  = invalid_cmd_evt;
  assign dv_set[`TDSR_DV_F_FAIL] = failure_evt;
  // the invalid command flag falls only through the serial access
  assign dv_clr = {`TDSR_DV_FLAG_W{clr_dev}};

  tdsr_sticky_flags
  #(
    .W (`TDSR_DV_FLAG_W)
  )
  u_dv_flags
  (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .flush   (soft_reset),
    .set     (dv_set),
    .clr     (dv_clr),
    .flags   (dv_flags)
  );

  ////////////////////////////////////////////////////////////////////
  // prior-mode field
  // a failure restart outranks a sleep code arriving in the same cycle
  always @*
  begin
    prior_d = prior_q;
    if (soft_reset)
      prior_d = `TDSR_PRIOR_CLEARED;
    else if (restart_fail_evt)
      prior_d = `TDSR_PRIOR_RESTART;
    else if (sleep_entry_evt || sleep_no_wake_evt)
      prior_d = `TDSR_PRIOR_SLEEP;
    else if (clr_dev)
      prior_d = `TDSR_PRIOR_CLEARED;
  end

  always @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      prior_q <= `TDSR_PRIOR_CLEARED;
    else
      prior_q <= prior_d;
  end

  ////////////////////////////////////////////////////////////////////
  // watchdog failure counter, saturating, cleared by the device only
  always @*
  begin
    wdc_d = wdc_q;
    if (soft_reset)
      wdc_d = `TDSR_WDC_ZERO;
    else if (watchdog_failure_counter_clear && watchdog_failure_counter_evt)
      wdc_d = `TDSR_WDC_ONE;
    else if (watchdog_failure_counter_clear)
      wdc_d = `TDSR_WDC_ZERO;
    else if (watchdog_failure_counter_evt && wdc_q != `TDSR_WDC_MAX)
      wdc_d = wdc_q + `TDSR_WDC_ONE;
  end

  always @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      wdc_q <= `TDSR_WDC_ZERO;
    else
      wdc_q <= wdc_d;
  end

  ////////////////////////////////////////////////////////////////////
  // hardware-updated mirrors
  always @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      swdev_q  <= 1'b0;
      crc_en_q <= 1'b0;
    end
    else
    begin
      swdev_q  <= software_development_indicator_mode;
      crc_en_q <= crc_enabled;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // register images; reserved bits are held at zero
  always @*
  begin
    therm_word = `TDSR_ZERO16;
    therm_word[`TDSR_TH_FLAG_W-1:0] = th_flags;
  end

  always @*
  begin
    dev_word = `TDSR_ZERO16;
    dev_word[`TDSR_DV_CRC_EN_BIT]   = crc_en_q;
    dev_word[`TDSR_DV_CRC_FAIL_BIT] = dv_flags[`TDSR_DV_F_CRC];
    dev_word[`TDSR_DV_PRIOR_HI:`TDSR_DV_PRIOR_LO] = prior_q;
    dev_word[`TDSR_DV_SWDEV_BIT]    = swdev_q;
    dev_word[`TDSR_DV_WDC_HI:`TDSR_DV_WDC_LO] = wdc_q;
    dev_word[`TDSR_DV_SPI_FAIL_BIT] = dv_flags[`TDSR_DV_F_SPI];
    dev_word[`TDSR_DV_FAILURE_BIT]  = dv_flags[`TDSR_DV_F_FAIL];
  end

  ////////////////////////////////////////////////////////////////////
  // read path: the image before any clear of the same access
  always @*
  begin
    rd_data_d = `TDSR_ZERO16;
    if (acc_therm)
      rd_data_d = therm_word;
    else if (acc_dev)
      rd_data_d = dev_word;
  end

  always @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rd_data_q  <= `TDSR_ZERO16;
      rd_valid_q <= 1'b0;
    end
    else
    begin
      rd_data_q  <= rd_data_d;
      rd_valid_q <= acc_therm || acc_dev;
    end
  end

endmodule

// File: verification/tdsr_status_regs_asserts.sv
// Purpose: port assertions for the status register bank
// Assumes: bound to tdsr_status_regs, single clock domain
// Notes:   read answers one cycle after the request
`timescale 1ns/1ps
`include "tdsr_consts.vh"
module tdsr_status_regs_asserts
(
  input wire        sys_clk,
  input wire        rst_n,
  input wire        soft_reset,
  input wire        cmd_valid,
  input wire [6:0]  cmd_addr,
  input wire        cmd_crc_ok,
  input wire        crc_enabled,
  input wire        prewarn_evt,
  input wire        local_sd_evt,
  input wire        severe_sd_evt,
  input wire        software_development_indicator_mode,
  input wire [15:0] rd_data_q,
  input wire        rd_valid_q,
  input wire        fail_safe_req_q,
  input wire        module_disable_q
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  sequence dev_rd;
    cmd_valid && cmd_addr == `TDSR_ADDR_DEV;
  endsequence
  sequence th_rd;
    cmd_valid && cmd_addr == `TDSR_ADDR_THERM
    && (!crc_enabled || cmd_crc_ok);
  endsequence
  ////////////////////////////////////////////////////////////////////////
  dev_answer_a: assert property (dev_rd |=> rd_valid_q)
    else $error("device register read not answered");
  therm_rsvd_a: assert property (
    th_rd |=> rd_valid_q && rd_data_q[15:4] == 12'h000)
    else $error("thermal read has reserved bits set");
  dev_rsvd_a: assert property (
    rd_valid_q |-> rd_data_q[15:10] == 6'h00 && !rd_data_q[5])
    else $error("reserved device bits not zero");
  fail_safe_a: assert property (severe_sd_evt |=> fail_safe_req_q)
    else $error("fail safe request missing");
  module_off_a: assert property (local_sd_evt |=> module_disable_q)
    else $error("module disable missing");
  crc_mirror_a: assert property (
    dev_rd ##0 $stable(crc_enabled)
    |=> rd_data_q[9] == $past(crc_enabled))
    else $error("checksum enable bit wrong");
  swdev_mirror_a: assert property (
    dev_rd ##0 $stable(software_development_indicator_mode)
    |=> rd_data_q[4] == $past(software_development_indicator_mode))
    else $error("development mode bit wrong");
  prewarn_seen_a: assert property (
    prewarn_evt && !soft_reset ##1 th_rd ##0 !soft_reset
    |=> rd_data_q[0])
    else $error("prewarning flag not reported");
endmodule
bind tdsr_status_regs tdsr_status_regs_asserts u_chk (.sys_clk, .rst_n,
  .soft_reset, .cmd_valid, .cmd_addr, .cmd_crc_ok, .crc_enabled, .prewarn_evt,
  .local_sd_evt, .severe_sd_evt, .software_development_indicator_mode, .rd_data_q, .rd_valid_q,
  .fail_safe_req_q, .module_disable_q);

// File: verification/tdsr_host_model.sv
// Purpose: host side issuing decoded serial register accesses
// Assumes: request held for one taking edge, answer stands after that edge
// Notes:   idle qualifiers show the inverse of the last request
`timescale 1ns/1ps
module tdsr_host_model
(
  input  wire        sys_clk,
  input  wire [15:0] rd_data_q,
  input  wire        rd_valid_q,
  output reg         cmd_valid,
  output reg  [6:0]  cmd_addr,
  output reg         cmd_rdclr,
  output reg         cmd_crc_ok
);
  initial
  begin
    cmd_valid  = 1'b0;
    cmd_addr   = 7'h00;
    cmd_rdclr  = 1'b0;
    cmd_crc_ok = 1'b0;
  end
  task access(input [6:0] a, input rc, input ok, input int gap,
              output [15:0] d, output v);
    repeat (gap) @(posedge sys_clk);
    @(posedge sys_clk);
    #1;
    cmd_valid  = 1'b1;
    cmd_addr   = a;
    cmd_rdclr  = rc;
    cmd_crc_ok = ok;
    @(posedge sys_clk);
    #1;
    // the answer stands from the taking edge until the next one
    d          = rd_data_q;
    v          = rd_valid_q;
    cmd_valid  = 1'b0;
    cmd_addr   = ~a;
    cmd_rdclr  = ~rc;
    cmd_crc_ok = ~ok;
  endtask
endmodule

// File: verification/tb_top.sv
// Purpose: self-checking bench of the status register bank
// Assumes: host model issues the accesses
// Notes:   events are one-cycle pulses
`timescale 1ns/1ps
module tb_top;
  logic        sys_clk;
  logic        rst_n;
  logic [12:0] ev;
  logic        crc_en;
  logic        seq;
  logic        sw;
  wire  [15:0] rdat;
  wire         rval;
  wire         cv;
  wire  [6:0]  ca;
  wire         crc;
  wire         cok;
  wire         fs;
  wire         md;
  wire         lw;
  int          failures;
  int          checks;
  tdsr_status_regs u_dut (.sys_clk(sys_clk), .rst_n(rst_n),
    .soft_reset(ev[12]), .cmd_valid(cv), .cmd_addr(ca), .cmd_rdclr(crc),
    .cmd_crc_ok(cok), .crc_enabled(crc_en), .crc_seq_active(seq),
    .crc_fail_evt(ev[11]), .prewarn_evt(ev[0]), .local_sd_evt(ev[1]),
    .severe_sd_evt(ev[2]), .severe_chain_break(ev[3]),
    .invalid_cmd_evt(ev[4]), .failure_evt(ev[5]), .restart_fail_evt(ev[6]),
    .sleep_entry_evt(ev[7]), .sleep_no_wake_evt(ev[8]),
    .software_development_indicator_mode(sw), .watchdog_failure_counter_evt(ev[9]), .watchdog_failure_counter_clear(ev[10]),
    .rd_data_q(rdat), .rd_valid_q(rval), .fail_safe_req_q(fs),
    .module_disable_q(md), .long_wait_sel_q(lw));
  tdsr_host_model u_host (.sys_clk(sys_clk), .rd_data_q(rdat),
    .rd_valid_q(rval), .cmd_valid(cv), .cmd_addr(ca), .cmd_rdclr(crc),
    .cmd_crc_ok(cok));
  ////////////////////////////////////////////////////////////////////////
  task chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp)
    begin
      failures++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task rd(input [6:0] a, input rc, input ok, input ev_ok, input [15:0] e);
    logic [15:0] d;
    logic        v;
    u_host.access(a, rc, ok, 0, d, v);
    chk({15'h0000, v}, {15'h0000, ev_ok});
    chk(d, e);
  endtask
  task pulse(input int i);
    @(posedge sys_clk);
    #1 ev[i] = 1'b1;
    @(posedge sys_clk);
    #1 ev[i] = 1'b0;
  endtask
  task t_therm;
    rd(7'h41, 0, 1, 1, 16'h0000);
    rd(7'h42, 0, 1, 1, 16'h0000);
    pulse(0);
    pulse(1);
    chk({15'h0000, md}, 16'h0001);
    pulse(2);
    chk({15'h0000, fs}, 16'h0001);
    chk({15'h0000, md}, 16'h0000);
    rd(7'h41, 0, 1, 1, 16'h0007);
    repeat (5) @(posedge sys_clk);
    rd(7'h41, 0, 1, 1, 16'h0007);
    rd(7'h41, 1, 1, 1, 16'h0007);
    rd(7'h41, 0, 1, 1, 16'h0000);
    // prewarning taken one cycle before the read is already reported
    @(posedge sys_clk);
    #1 ev[0] = 1'b1;
    fork
      begin
        @(posedge sys_clk);
        #1 ev[0] = 1'b0;
      end
      rd(7'h41, 1, 1, 1, 16'h0001);
    join
    // an event on the clearing edge survives the read-and-clear
    fork
      begin
        @(posedge sys_clk);
        #1 ev[1] = 1'b1;
        @(posedge sys_clk);
        #1 ev[1] = 1'b0;
      end
      rd(7'h41, 1, 1, 1, 16'h0000);
    join
    rd(7'h41, 1, 1, 1, 16'h0002);
    crc_en = 1'b1;
    rd(7'h41, 1, 0, 0, 16'h0000);
    rd(7'h43, 0, 1, 0, 16'h0000);
    crc_en = 1'b0;
    $display("test therm done");
  endtask
  task t_safe;
    // break the chain left over from the earlier severe event
    pulse(3);
    repeat (16) pulse(2);
    chk({15'h0000, lw}, 16'h0000);
    rd(7'h41, 1, 1, 1, 16'h0004);
    pulse(2);
    chk({15'h0000, lw}, 16'h0001);
    rd(7'h41, 1, 1, 1, 16'h000C);
    pulse(3);
    chk({15'h0000, lw}, 16'h0000);
    pulse(0);
    pulse(12);
    rd(7'h41, 0, 1, 1, 16'h0000);
    $display("test safe done");
  endtask
  task t_dev;
    crc_en = 1'b1;
    sw = 1'b1;
    seq = 1'b1;
    pulse(11);
    seq = 1'b0;
    rd(7'h42, 0, 1, 1, 16'h0210);
    pulse(11);
    rd(7'h42, 0, 0, 1, 16'h0310);
    repeat (5) pulse(9);
    pulse(4);
    pulse(5);
    pulse(6);
    rd(7'h42, 1, 1, 1, 16'h035F);
    rd(7'h42, 0, 1, 1, 16'h021C);
    pulse(8);
    rd(7'h42, 1, 1, 1, 16'h029C);
    pulse(7);
    rd(7'h42, 1, 1, 1, 16'h029C);
    sw = 1'b0;
    pulse(10);
    pulse(9);
    rd(7'h42, 0, 1, 1, 16'h0204);
    $display("test dev done");
  endtask
  task give_verdict;
    $display("checks=%0d failures=%0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end
  initial
  begin
    rst_n = 1'b0;
    ev = 13'h0000;
    crc_en = 1'b0;
    seq = 1'b0;
    sw = 1'b0;
    failures = 0;
    checks = 0;
    repeat (6) @(posedge sys_clk);
    #1 rst_n = 1'b1;
    t_therm;
    t_safe;
    t_dev;
    give_verdict;
  end
endmodule
